/* logic/rcio_top.sv */
/*
 Remote contact I/O function map of an indoor unit control board, with an
 APB register slave for function codes, local controller commands, status.
 Assumes a 40 MHz pclk, asynchronous active-low presetn, dry contacts on
 contact_raw, and plant status inputs on the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module rcio_top
	import rcio_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = INIT_CYC_DEF,
	parameter int unsigned DEB_CYCLES  = DEB_CYC_DEF
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [NUM_IN-1:0]  contact_raw,
	input  wire logic               alarm_active,
	input  wire logic               thermo_on,
	input  wire logic               hrv_active,
	output logic      [NUM_OUT-1:0] contact_out_q,
	output logic                    unit_run_q,
	output logic                    heat_mode_q,
	output logic                    forced_stop_q,
	output logic                    cool_demand_q,
	output logic                    heat_demand_q,
	output logic                    setback_q
);

	// Elaboration checks
	if (INIT_CYCLES < 1) begin : g_chk_init
		$error("INIT_CYCLES must be at least 1");
	end
	if (DEB_CYCLES < 1) begin : g_chk_deb
		$error("DEB_CYCLES must be at least 1");
	end

	localparam int unsigned IW = $clog2(INIT_CYCLES + 1);

	// Which inputs carry a given function code
	function automatic logic [NUM_IN-1:0] fn_mask(
		input logic [2*CODE_W-1:0] codes,
		input logic [CODE_W-1:0]   fn
	);
		logic [NUM_IN-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			m[i] = (codes[i*CODE_W +: CODE_W] == fn);
		end
		return m;
	endfunction

	// Drive level of one output terminal for its code
	function automatic logic out_level(
		input logic [CODE_W-1:0] code,
		input logic run,
		input logic heat,
		input logic alarm,
		input logic thermo,
		input logic hrv
	);
		logic v;
		case (code)
			OUT_RUN:      v = run;
			OUT_ALARM:    v = alarm;
			OUT_COOL:     v = run & ~heat;
			OUT_COOL_DEM: v = run & ~heat & thermo;
			OUT_HEAT:     v = run & heat;
			OUT_HEAT_DEM: v = run & heat & thermo;
			OUT_HRV:      v = hrv;
			default:      v = 1'b0;
		endcase
		return v;
	endfunction

	// Debounced contact levels, closed reads as one
	logic [NUM_IN-1:0] db_lvl;

	for (genvar g = 0; g < NUM_IN; g++) begin : g_in
		rcio_debounce #(
			.DEB_CYCLES (DEB_CYCLES)
		) u_deb (
			.pclk        (pclk),
			.presetn     (presetn),
			.contact_raw (contact_raw[g]),
			.level_q     (db_lvl[g])
		);
	end

	// APB registers and state
	logic [2:0]             ctrl_q, ctrl_d;
	logic [2*CODE_W-1:0]    in_func_q, in_func_d;
	logic [3*CODE_W-1:0]    out_func_q, out_func_d;
	logic [31:0]            prdata_d;
	logic                   pready_d, pslverr_d;
	logic                   wr_en;
	logic [31:0]            cmd;
	logic                   addr_ok;

	// Startup and control state
	logic [IW-1:0]          init_cnt_q, init_cnt_d;
	logic                   init_done_q, init_done_d;
	logic                   init_first_q, init_first_d;
	logic [NUM_IN-1:0]      prev_q;
	rcio_menu_t             menu_q, menu_d;
	logic                   run_d, heat_d, forced_d;
	logic                   cdem_d, hdem_d, setback_d;
	logic [NUM_OUT-1:0]     cout_d;

	// Decode helpers
	logic                   remote_ok, brk, conn, single;
	logic [NUM_IN-1:0]      rise, chg;
	logic [NUM_IN-1:0]      m_lvl, m_prun, m_pstop, m_forced, m_mode;
	logic                   ev_level, ev_prun, ev_pstop, ev_mode;
	logic                   local_cmd;

	assign brk    = ctrl_q[CTRL_BRK];
	assign conn   = ctrl_q[CTRL_CONN];
	assign single = ctrl_q[CTRL_SINGLE];

	// APB write strobe and command pulses
	assign wr_en   = psel & penable & pready & pwrite;
	assign cmd     = (wr_en && paddr == ADDR_CMD) ? pwdata : 32'h0000_0000;
	assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_IN_FUNC)
		|| (paddr == ADDR_OUT_FUNC) || (paddr == ADDR_CMD)
		|| (paddr == ADDR_STATUS);

	// APB slave: one wait state, answer registered
	always_comb begin
		ctrl_d     = ctrl_q;
		in_func_d  = in_func_q;
		out_func_d = out_func_q;
		pready_d   = psel & penable & ~pready;
		pslverr_d  = 1'b0;
		prdata_d   = 32'h0000_0000;
		if (psel && penable && !pready) begin
			pslverr_d = ~addr_ok;
			if (!pwrite) begin
				case (paddr)
					ADDR_CTRL:     prdata_d = {29'h0, ctrl_q};
					ADDR_IN_FUNC:  prdata_d = {16'h0, in_func_q};
					ADDR_OUT_FUNC: prdata_d = {8'h0, out_func_q};
					ADDR_STATUS: begin
						prdata_d[ST_RUN]     = unit_run_q;
						prdata_d[ST_FORCED]  = forced_stop_q;
						prdata_d[ST_INIT]    = init_done_q;
						prdata_d[ST_HEAT]    = heat_mode_q;
						prdata_d[ST_CTHERMO] = cool_demand_q;
						prdata_d[ST_HTHERMO] = heat_demand_q;
						prdata_d[ST_SETBACK] = setback_q;
						prdata_d[ST_MENU_LSB +: 3] = menu_q;
						prdata_d[ST_IN_LSB +: NUM_IN] = db_lvl;
						prdata_d[ST_OUT_LSB +: NUM_OUT] = contact_out_q;
					end
					default:       prdata_d = 32'h0000_0000;
				endcase
			end
		end
		if (wr_en) begin
			case (paddr)
				ADDR_CTRL:     ctrl_d = pwdata[2:0];
				ADDR_IN_FUNC:  in_func_d = pwdata[2*CODE_W-1:0];
				ADDR_OUT_FUNC: out_func_d = pwdata[3*CODE_W-1:0];
				default:       ctrl_d = ctrl_q;
			endcase
		end
	end

	// APB registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= CTRL_RST;
			in_func_q  <= IN_FUNC_RST;
			out_func_q <= OUT_FUNC_RST;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			in_func_q  <= in_func_d;
			out_func_q <= out_func_d;
			prdata     <= prdata_d;
			pready     <= pready_d;
			pslverr    <= pslverr_d;
		end
	end

	// Function decode of the debounced inputs
	assign rise      = db_lvl & ~prev_q & {NUM_IN{init_done_q}};
	assign chg       = (db_lvl ^ prev_q) & {NUM_IN{init_done_q}};
	assign m_lvl     = fn_mask(in_func_q, IN_LEVEL_RUN);
	assign m_prun    = fn_mask(in_func_q, IN_PULSE_RUN);
	assign m_pstop   = fn_mask(in_func_q, IN_PULSE_STOP);
	assign m_forced  = fn_mask(in_func_q, IN_FORCED);
	assign m_mode    = fn_mask(in_func_q, IN_MODE_CHG);
	assign remote_ok = init_done_q & conn;
	assign ev_level  = remote_ok & |(m_lvl & (chg | {NUM_IN{init_first_q}}));
	assign ev_prun   = remote_ok & |(m_prun & rise);
	assign ev_pstop  = remote_ok & |(m_pstop & rise);
	assign ev_mode   = remote_ok & |(m_mode & chg);
	assign local_cmd = |cmd[CMD_CSTOP:CMD_RUN];

	// Start-up hold, run state, mode, forced stop, menu
	always_comb begin
		init_cnt_d   = init_cnt_q;
		init_done_d  = init_done_q;
		init_first_d = 1'b0;
		if (!init_done_q) begin
			if (init_cnt_q == IW'(INIT_CYCLES - 1)) begin
				init_done_d  = 1'b1;
				init_first_d = 1'b1;
			end else begin
				init_cnt_d = init_cnt_q + IW'(1);
			end
		end
		// Break-contact option inverts the forced-stop sense
		forced_d = init_done_q &
			|(m_forced & (db_lvl ^ {NUM_IN{brk}}));
		run_d = unit_run_q;
		if (forced_d) begin
			run_d = 1'b0;
		end else begin
			if (cmd[CMD_RUN] || cmd[CMD_CRUN]) begin
				run_d = 1'b1;
			end
			if (cmd[CMD_STOP] || cmd[CMD_CSTOP]) begin
				run_d = 1'b0;
			end
			if (ev_level) begin
				run_d = |(m_lvl & db_lvl);
			end
			if (ev_prun) begin
				run_d = ~unit_run_q;
			end
			if (ev_pstop) begin
				run_d = 1'b0;
			end
		end
		// Latest of input edge and local command sets the mode; the input edge wins if both come in one cycle
		heat_d = heat_mode_q;
		if (cmd[CMD_COOL]) begin
			heat_d = 1'b0;
		end
		if (cmd[CMD_HEAT]) begin
			heat_d = 1'b1;
		end
		if (ev_mode) begin
			heat_d = |(m_mode & db_lvl);
		end
		cdem_d = init_done_q & |(fn_mask(in_func_q, IN_COOL_TSTAT) & db_lvl);
		hdem_d = init_done_q & |(fn_mask(in_func_q, IN_HEAT_TSTAT) & db_lvl);
		setback_d = init_done_q & |(fn_mask(in_func_q, IN_SETBACK) & db_lvl);
		for (int o = 0; o < NUM_OUT; o++) begin
			cout_d[o] = out_level(out_func_q[o*CODE_W +: CODE_W],
				unit_run_q, heat_mode_q, alarm_active, thermo_on,
				hrv_active);
		end
		// Setting menu navigation
		menu_d = menu_q;
		if (cmd[CMD_BACK]) begin
			case (menu_q)
				MENU_S4, MENU_S5: menu_d = single ? MENU_S1 : MENU_S3;
				default:          menu_d = MENU_S1;
			endcase
		end else begin
			case (cmd[CMD_GOTO_LSB +: 3])
				3'h1:    menu_d = MENU_S1;
				3'h2:    menu_d = MENU_S2;
				3'h3:    menu_d = MENU_S3;
				3'h4:    menu_d = MENU_S4;
				3'h5:    menu_d = MENU_S5;
				default: menu_d = menu_q;
			endcase
		end
	end

	// Control registers; run state is the group command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_q    <= '0;
			init_done_q   <= 1'b0;
			init_first_q  <= 1'b0;
			prev_q        <= '0;
			menu_q        <= MENU_S1;
			unit_run_q    <= 1'b0;
			heat_mode_q   <= 1'b0;
			forced_stop_q <= 1'b0;
			cool_demand_q <= 1'b0;
			heat_demand_q <= 1'b0;
			setback_q     <= 1'b0;
			contact_out_q <= '0;
		end else begin
			init_cnt_q    <= init_cnt_d;
			init_done_q   <= init_done_d;
			init_first_q  <= init_first_d;
			prev_q        <= db_lvl;
			menu_q        <= menu_d;
			unit_run_q    <= run_d;
			heat_mode_q   <= heat_d;
			forced_stop_q <= forced_d;
			cool_demand_q <= cdem_d;
			heat_demand_q <= hdem_d;
			setback_q     <= setback_d;
			contact_out_q <= cout_d;
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	forced_halt_a: assert property (forced_stop_q |-> !unit_run_q)
		else $error("unit runs during forced stop");
	init_quiet_a: assert property (!init_done_q |-> !forced_stop_q
		&& !setback_q && !cool_demand_q)
		else $error("input acted before start-up hold ended");
	level_run_a: assert property (ev_level && !forced_d
		&& !ev_prun && !ev_pstop |=> unit_run_q == $past(|(m_lvl & db_lvl)))
		else $error("level input not followed");
	pulse_toggle_a: assert property (ev_prun && !forced_d && !ev_pstop
		|=> unit_run_q != $past(unit_run_q))
		else $error("run pulse did not toggle");
	stop_pulse_a: assert property (ev_pstop |=> !unit_run_q)
		else $error("stop pulse did not stop");
	remote_block_a: assert property (forced_stop_q && forced_d
		&& (ev_prun || cmd[CMD_CRUN]) |=> !unit_run_q)
		else $error("run accepted during forced stop");
	break_logic_a: assert property (init_done_q && brk
		&& |(m_forced & ~db_lvl) |=> forced_stop_q)
		else $error("open break contact did not force stop");
	no_ctrl_a: assert property (!conn && !local_cmd && !forced_d
		|=> $stable(unit_run_q))
		else $error("remote input acted without controller");
	menu_back_a: assert property (cmd[CMD_BACK]
		&& (menu_q == MENU_S4 || menu_q == MENU_S5)
		|=> menu_q == (single ? MENU_S1 : MENU_S3))
		else $error("back from screen 4 or 5 misrouted");
	mode_edge_a: assert property (ev_mode
		|=> heat_mode_q == $past(|(m_mode & db_lvl)))
		else $error("mode input edge not applied");

	level_seen_c: cover property (ev_level ##1 unit_run_q);
	pulse_seen_c: cover property (ev_prun ##[1:50] ev_pstop);
	forced_seen_c: cover property (unit_run_q ##1 forced_stop_q);
	menu_seen_c: cover property (menu_q == MENU_S5 ##1 menu_q == MENU_S3);

endmodule

`default_nettype wire

/* logic/rcio_pkg.sv */
/*
 Package for the remote contact I/O function block: register map, field
 positions, reset codes, function codes, timing constants, menu states.
 Assumes a 40 MHz APB clock and one asynchronous active-low reset.
*/
`default_nettype none

package rcio_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned INIT_TIME_S   = 10;
	localparam int unsigned INIT_CYC_DEF  = INIT_TIME_S * CLK_HZ;
	localparam int unsigned DEB_TIME_MS   = 20;
	localparam int unsigned DEB_CYC_DEF   = (CLK_HZ / 1000) * DEB_TIME_MS;

	// Terminal counts
	localparam int unsigned NUM_IN        = 2;
	localparam int unsigned NUM_OUT       = 3;

	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_IN_FUNC  = 8'h04;
	localparam logic [7:0]  ADDR_OUT_FUNC = 8'h08;
	localparam logic [7:0]  ADDR_CMD      = 8'h0c;
	localparam logic [7:0]  ADDR_STATUS   = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_BRK      = 0;
	localparam int unsigned CTRL_CONN     = 1;
	localparam int unsigned CTRL_SINGLE   = 2;
	localparam logic [2:0]  CTRL_RST      = 3'h2;

	// Command register fields (write-only pulses)
	localparam int unsigned CMD_RUN       = 0;
	localparam int unsigned CMD_STOP      = 1;
	localparam int unsigned CMD_CRUN      = 2;
	localparam int unsigned CMD_CSTOP     = 3;
	localparam int unsigned CMD_COOL      = 4;
	localparam int unsigned CMD_HEAT      = 5;
	localparam int unsigned CMD_BACK      = 6;
	localparam int unsigned CMD_GOTO_LSB  = 8;

	// Status register fields
	localparam int unsigned ST_RUN        = 0;
	localparam int unsigned ST_FORCED     = 1;
	localparam int unsigned ST_INIT       = 2;
	localparam int unsigned ST_HEAT       = 3;
	localparam int unsigned ST_CTHERMO    = 4;
	localparam int unsigned ST_HTHERMO    = 5;
	localparam int unsigned ST_SETBACK    = 6;
	localparam int unsigned ST_MENU_LSB   = 8;
	localparam int unsigned ST_IN_LSB     = 12;
	localparam int unsigned ST_OUT_LSB    = 16;

	// Function code fields are one byte per terminal
	localparam int unsigned CODE_W        = 8;

	// Input function codes
	localparam logic [7:0]  IN_UNUSED     = 8'h00;
	localparam logic [7:0]  IN_COOL_TSTAT = 8'h01;
	localparam logic [7:0]  IN_HEAT_TSTAT = 8'h02;
	localparam logic [7:0]  IN_LEVEL_RUN  = 8'h03;
	localparam logic [7:0]  IN_PULSE_RUN  = 8'h04;
	localparam logic [7:0]  IN_PULSE_STOP = 8'h05;
	localparam logic [7:0]  IN_FORCED     = 8'h06;
	localparam logic [7:0]  IN_MODE_CHG   = 8'h07;
	localparam logic [7:0]  IN_SETBACK    = 8'h09;

	// Output function codes
	localparam logic [7:0]  OUT_UNUSED    = 8'h00;
	localparam logic [7:0]  OUT_RUN       = 8'h01;
	localparam logic [7:0]  OUT_ALARM     = 8'h02;
	localparam logic [7:0]  OUT_COOL      = 8'h03;
	localparam logic [7:0]  OUT_COOL_DEM  = 8'h04;
	localparam logic [7:0]  OUT_HEAT      = 8'h05;
	localparam logic [7:0]  OUT_HEAT_DEM  = 8'h06;
	localparam logic [7:0]  OUT_HRV       = 8'h07;

	// Reset function assignment
	localparam logic [15:0] IN_FUNC_RST   = 16'h0603;
	localparam logic [23:0] OUT_FUNC_RST  = 24'h060201;

	// Setting menu screens
	typedef enum logic [2:0] {
		MENU_S1,
		MENU_S2,
		MENU_S3,
		MENU_S4,
		MENU_S5
	} rcio_menu_t;

endpackage

`default_nettype wire

/* logic/rcio_debounce.sv */
/*
 Contact input conditioner: two-flop synchroniser then a stability counter.
 Assumes a raw dry-contact level that is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module rcio_debounce #(
	parameter int unsigned DEB_CYCLES = 800_000
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic contact_raw,
	output logic      level_q
);

	localparam int unsigned CW = $clog2(DEB_CYCLES + 1);

	logic          sync1_q;
	logic          sync2_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          level_d;

	// Count while the synchronised level differs from the held one
	always_comb begin
		cnt_d   = '0;
		level_d = level_q;
		if (sync2_q != level_q) begin
			if (cnt_q == CW'(DEB_CYCLES - 1)) begin
				level_d = sync2_q;
			end else begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	// Synchroniser and debounce registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else begin
			sync1_q <= contact_raw;
			sync2_q <= sync1_q;
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end

endmodule

`default_nettype wire

/* tb/rcio_bms.sv */
/*
 Building management side: dry contacts driving the two contact inputs.
 Assumes pclk and presetn of the bench; tasks are called by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module rcio_bms #(
	parameter int unsigned GUARD = 30,
	parameter int unsigned HOLD  = 12
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	output logic      [1:0] contact_raw
);
	int unsigned up_cnt;

	// Cycles since reset release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_cnt <= 0;
		else if (up_cnt < GUARD)
			up_cnt <= up_cnt + 1;
	end

	// Input 1 closed, input 2 open from power-up
	initial contact_raw = 2'b01;

	// Contacts stay put until start-up is over
	// One unit's contact acts for the whole group
	task automatic set(input int i, input logic v);
		for (int n = 0; n < GUARD && up_cnt < GUARD; n++)
			@(posedge pclk);
		@(posedge pclk);
		contact_raw[i] <= v;
		repeat (HOLD) @(posedge pclk);
	endtask

	// Momentary closure then release
	task automatic pulse(input int i);
		set(i, 1'b1);
		set(i, 1'b0);
	endtask
endmodule

`default_nettype wire

/* tb/rcio_top_bench.sv */
/*
 Self-checking bench: APB master, contact partner, read scoreboard.
 Assumes the package and rcio_top with short init and debounce counts.
*/
`timescale 1ns/1ps
`default_nettype none

module rcio_top_bench;
	import rcio_pkg::*;
	localparam int unsigned INIT_C = 20;
	localparam int unsigned DEB_C  = 4;

	typedef struct {
		logic [31:0] dat;
		logic [31:0] msk;
		logic        err;
	} rcio_exp_t;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  contact_raw;
	logic        alarm_active = 1'b0;
	logic        thermo_on = 1'b0;
	logic        hrv_active = 1'b0;
	logic [2:0]  contact_out_q;
	logic        unit_run_q;
	logic        heat_mode_q;
	logic        forced_stop_q;
	logic        cool_demand_q;
	logic        heat_demand_q;
	logic        setback_q;
	logic [8:0]  pins;
	// Bit positions of the level pins inside pins
	localparam int P_RUN  = 3;
	localparam int P_HEAT = 4;
	localparam int P_FRC  = 5;
	localparam int P_CDEM = 6;
	localparam int P_HDEM = 7;
	localparam int P_SETB = 8;
	logic [31:0] seed = 32'ha6b9;
	rcio_exp_t   exp_q[$];
	int          error_cnt = 0;
	int          checked = 0;

	always #12.5 pclk = ~pclk;

	rcio_top #(.INIT_CYCLES(INIT_C), .DEB_CYCLES(DEB_C)) u_rcio_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .contact_raw(contact_raw),
		.alarm_active(alarm_active), .thermo_on(thermo_on),
		.hrv_active(hrv_active), .contact_out_q(contact_out_q),
		.unit_run_q(unit_run_q), .heat_mode_q(heat_mode_q),
		.forced_stop_q(forced_stop_q), .cool_demand_q(cool_demand_q),
		.heat_demand_q(heat_demand_q), .setback_q(setback_q)
	);

	// All level outputs in one word for the pin checks
	assign pins = {setback_q, heat_demand_q, cool_demand_q, forced_stop_q,
		heat_mode_q, unit_run_q, contact_out_q};

	rcio_bms #(.GUARD(INIT_C + 4), .HOLD(DEB_C + 8)) u_bms (
		.pclk(pclk), .presetn(presetn), .contact_raw(contact_raw)
	);

	// Verdict and end of run
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Compare one read word and its error flag under a mask
	task automatic cmp(input rcio_exp_t e, input logic [31:0] d,
		input logic r);
		checked++;
		if (((d & e.msk) !== e.dat) || (r !== e.err)) begin
			error_cnt++;
			$display("BAD t=%0t got %h/%h exp %h/%h", $time, d, r,
				e.dat, e.err);
		end
	endtask

	// Compare one output pin off the edge, then realign to a rising edge
	task automatic pin(input int k, input logic e);
		@(negedge pclk);
		checked++;
		if (pins[k] !== e) begin
			error_cnt++;
			$display("BAD t=%0t pin %0d got %h exp %h", $time, k,
				pins[k], e);
		end
		@(posedge pclk);
	endtask

	// Scoreboard side: each read answer against the oldest note
	always @(negedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0)
				error_cnt++;
			else
				cmp(exp_q.pop_front(), prdata, pslverr);
		end
	end

	// One APB transfer, held to the rising edge after pready is seen at a falling edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 50) begin
			error_cnt++;
			finish_test();
		end
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic r);
		exp_q.push_back('{dat: d & m, msk: m, err: r});
		apb(1'b0, a, 32'h0);
	endtask

	task automatic sb(input int b, input logic v);
		rd(ADDR_STATUS, 32'(v) << b, 32'h1 << b, 1'b0);
	endtask

	logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h07, 8'h09};
	logic       ob;

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		sb(ST_INIT, 1'b0);
		sb(ST_RUN, 1'b0);
		rd(ADDR_CTRL, 32'h2, 32'hffffffff, 1'b0);
		rd(ADDR_IN_FUNC, 32'h0603, 32'hffffffff, 1'b0);
		rd(ADDR_OUT_FUNC, 32'h060201, 32'hffffffff, 1'b0);
		rd(8'h14, 32'h0, 32'hffffffff, 1'b1);
		rd(ADDR_CMD, 32'h0, 32'hffffffff, 1'b0);
		repeat (INIT_C + 10) @(posedge pclk); // Settle before setup
		sb(ST_INIT, 1'b1);
		sb(ST_RUN, 1'b1);
		u_bms.set(0, 1'b0);
		sb(ST_RUN, 1'b0);
		u_bms.set(0, 1'b1);
		// Output codes in cooling operation with random plant inputs
		foreach (codes[i]) begin
			seed = lfsr(seed);
			alarm_active <= seed[0];
			thermo_on <= seed[1];
			hrv_active <= seed[2];
			apb(1'b1, ADDR_OUT_FUNC, {16'h0602, codes[i]});
			case (codes[i])
				8'h01, 8'h03: ob = 1'b1;
				8'h02: ob = seed[0];
				8'h04: ob = seed[1];
				8'h07: ob = seed[2];
				default: ob = 1'b0;
			endcase
			sb(ST_OUT_LSB, ob);
			pin(0, ob);
		end
		u_bms.set(0, 1'b0);
		apb(1'b1, ADDR_IN_FUNC, 32'h0604);
		u_bms.pulse(0);
		sb(ST_RUN, 1'b1);
		pin(P_RUN, 1'b1);
		u_bms.pulse(0);
		sb(ST_RUN, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		u_bms.pulse(0);
		sb(ST_RUN, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h2);
		apb(1'b1, ADDR_IN_FUNC, 32'h0605);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_RUN);
		pin(P_RUN, 1'b1);
		u_bms.pulse(0);
		sb(ST_RUN, 1'b0);
		u_bms.pulse(0);
		sb(ST_RUN, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_RUN);
		sb(ST_RUN, 1'b1);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_STOP);
		pin(P_RUN, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_CRUN);
		pin(P_RUN, 1'b1);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_CSTOP);
		pin(P_RUN, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_RUN);
		pin(P_RUN, 1'b1);
		u_bms.set(1, 1'b1);
		sb(ST_FORCED, 1'b1);
		pin(P_FRC, 1'b1);
		sb(ST_RUN, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_RUN);
		sb(ST_RUN, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_CRUN);
		sb(ST_RUN, 1'b0);
		apb(1'b1, ADDR_IN_FUNC, 32'h0604);
		u_bms.pulse(0);
		sb(ST_RUN, 1'b0);
		u_bms.set(1, 1'b0);
		sb(ST_FORCED, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		repeat (4) @(posedge pclk);
		sb(ST_FORCED, 1'b1);
		u_bms.set(1, 1'b1);
		sb(ST_FORCED, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h2);
		u_bms.set(1, 1'b0);
		apb(1'b1, ADDR_IN_FUNC, 32'h0607);
		u_bms.set(0, 1'b1);
		sb(ST_HEAT, 1'b1);
		u_bms.set(0, 1'b0);
		sb(ST_HEAT, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_HEAT);
		pin(P_HEAT, 1'b1);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_COOL);
		pin(P_HEAT, 1'b0);
		// Thermostat codes on the first input, setback code on the second
		apb(1'b1, ADDR_IN_FUNC, 32'h0901);
		u_bms.set(0, 1'b1);
		u_bms.set(1, 1'b1);
		pin(P_CDEM, 1'b1);
		pin(P_SETB, 1'b1);
		sb(ST_SETBACK, 1'b1);
		apb(1'b1, ADDR_IN_FUNC, 32'h0002);
		pin(P_HDEM, 1'b1);
		pin(P_CDEM, 1'b0);
		pin(P_SETB, 1'b0);
		u_bms.set(0, 1'b0);
		apb(1'b1, ADDR_CMD, 32'h4 << CMD_GOTO_LSB);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_BACK);
		rd(ADDR_STATUS, 32'h2 << ST_MENU_LSB, 32'h7 << ST_MENU_LSB,
			1'b0);
		apb(1'b1, ADDR_CTRL, 32'h6);
		apb(1'b1, ADDR_CMD, 32'h5 << CMD_GOTO_LSB);
		apb(1'b1, ADDR_CMD, 32'h1 << CMD_BACK);
		rd(ADDR_STATUS, 32'h0, 32'h7 << ST_MENU_LSB, 1'b0);
		repeat (4) @(posedge pclk);
		if (exp_q.size() != 0)
			error_cnt++;
		finish_test();
	end
endmodule

`default_nettype wire
